// ==== bench/lsst_properties.sv ====
// Concurrent checks on the pins between sensor and controller.
// Assumes one system clock and an async active high reset for both ends.
`timescale 1ns/1ps

module lsst_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic pix_clk,
    input wire logic scan_start_pulse,
    input wire logic trig,
    input wire lsst_pkg::lsst_video_t video
);
    logic [4:0] hcnt_r;
    logic [7:0] lcnt_r;
    logic [11:0] tcnt_r;
    logic pc_seen_r, st_seen_r, pc_q_r, st_q_r, trig_q_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Phase length, pixel clocks per start level, triggers since start fell
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {pc_q_r, st_q_r, trig_q_r, pc_seen_r, st_seen_r} <= 5'h00;
            hcnt_r <= 5'h00;
            lcnt_r <= 8'h00;
            tcnt_r <= 12'h000;
        end else begin
            pc_q_r <= pix_clk;
            st_q_r <= scan_start_pulse;
            trig_q_r <= trig;
            hcnt_r <= (pix_clk != pc_q_r) ? 5'h00 : hcnt_r + 5'h01;
            if (pix_clk != pc_q_r) pc_seen_r <= 1'b1;
            if (scan_start_pulse != st_q_r) lcnt_r <= 8'h00;
            else if (pix_clk && !pc_q_r && lcnt_r != 8'hff) lcnt_r <= lcnt_r + 8'h01;
            if (!scan_start_pulse && st_q_r) begin
                tcnt_r <= 12'h000;
                st_seen_r <= 1'b1;
            end else if (trig && !trig_q_r && tcnt_r != 12'hfff) tcnt_r <= tcnt_r + 12'h001;
        end
    end

    chk_pix_half_period: assert property ($changed(pix_clk) && pc_seen_r |-> hcnt_r == 5'h0c)
        else $error("pixel clock phase length wrong");
    chk_start_high_min: assert property ($fell(scan_start_pulse) |-> lcnt_r >= 8'h06)
        else $error("start pulse high too short");
    chk_start_low_min: assert property ($rose(scan_start_pulse) && st_seen_r |-> lcnt_r >= 8'h40)
        else $error("start pulse low too short");
    chk_scan_gap: assert property ($rose(scan_start_pulse) && st_seen_r |-> tcnt_r >= 12'h9f2)
        else $error("scan restarted before readout ended");
    chk_shift_start: assert property ($fell(scan_start_pulse) |-> ##[1:17] $rose(trig))
        else $error("no trigger after start fell");
    chk_trig_align: assert property ($rose(trig) |-> $past(pix_clk, 3) && !$past(pix_clk, 4))
        else $error("trigger not aligned to pixel clock");
    chk_trig_width: assert property ($rose(trig) |-> trig[*8] ##1 trig[*5] ##1 !trig)
        else $error("trigger width wrong");
    chk_lead_zero: assert property ($rose(trig) && st_seen_r && tcnt_r < 12'h032 |-> video == 12'h000)
        else $error("video nonzero before first pixel");
    chk_readout_len: assert property ($rose(trig) |-> tcnt_r < 12'h9f2)
        else $error("too many triggers in one scan");

    // Main scenarios reached
    cov_start_rise: cover property ($rose(scan_start_pulse) && st_seen_r);
    cov_start_fall: cover property ($fell(scan_start_pulse));
    cov_last_trig: cover property ($rose(trig) && tcnt_r == 12'h9f1);
endmodule

// ==== bench/tb_linear_sensor_scan_timing.sv ====
// Testbench: sensor and controller joined by the link, user sides driven.
// Assumes the core files are compiled first; inputs change at falling edges.
`timescale 1ns/1ps
`include "lsst_cfg.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end end

module tb_linear_sensor_scan_timing;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic run = 1'b0;
    logic pix_ready = 1'b0;
    logic [15:0] high_len = 16'h0003;
    logic [15:0] rnd = 16'h001d;
    lsst_pkg::lsst_video_t light_level = 12'h080;
    lsst_pkg::lsst_video_t exposure, pix_data, base, w;
    logic integrating, reading, scan_busy, overrun, pix_valid, hit;
    logic [19:0] integ_len;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int got;
    int k;

    lsst_if lsst_if_i ();
    lsst_sensor lsst_sensor_i (.clk(clk), .reset(reset), .ce(ce), .link(lsst_if_i), .light_level(light_level),
        .integrating(integrating), .reading(reading), .integ_len(integ_len), .exposure(exposure));
    lsst_ctrl lsst_ctrl_i (.clk(clk), .reset(reset), .ce(ce), .link(lsst_if_i), .run(run), .high_len(high_len),
        .pix_data(pix_data), .pix_valid(pix_valid), .pix_ready(pix_ready), .scan_busy(scan_busy), .overrun(overrun));
    lsst_properties lsst_properties_i (.clk(clk), .reset(reset), .pix_clk(lsst_if_i.pix_clk),
        .scan_start_pulse(lsst_if_i.scan_start_pulse), .trig(lsst_if_i.trig), .video(lsst_if_i.video));

    // 250 MHz system clock
    always #2 clk = ~clk;

    // Pseudo random source
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Word for a pixel when all pixels share one exposure
    function automatic lsst_pkg::lsst_video_t pix_word(input lsst_pkg::lsst_video_t b, input int i);
        return b ^ i[11:0];
    endfunction

    // Saturated exposure for a level floor over n pixel clocks
    function automatic lsst_pkg::lsst_video_t sat_exp(input int lvl, input int n);
        return (lvl * n > 4095) ? 12'hfff : 12'(lvl * n);
    endfunction

    // High time the controller applies for a requested length
    function automatic int high_eff_of(input int h);
        return (h < `LSST_ST_HIGH_MIN) ? `LSST_ST_HIGH_MIN : h;
    endfunction

    // Counts, verdict, end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One falling edge: new light level, ready, and the word popped at the next rise
    task automatic pull(input logic rdy, output logic hit_o, output lsst_pkg::lsst_video_t w_o);
        @(negedge clk);
        rnd = lfsr_next(rnd);
        light_level = {4'h0, rnd[7:0]} | 12'h080;
        pix_ready = rdy;
        hit_o = rdy && (pix_valid === 1'b1);
        w_o = pix_data;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            $display("FAIL %s exp %h got %h", "timeout", 1'b1, 1'b0);
            close_out();
        end
    end

    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        `CHK("pix_valid", 1'b0, pix_valid)
        `CHK("overrun", 1'b0, overrun)
        `CHK("start", 1'b0, lsst_if_i.scan_start_pulse)
        `CHK("exposure", 12'h000, exposure)
        reset = 1'b0;
        $display("test reset done");
        run = 1'b1;
        got = 0;
        base = sat_exp(12'h080, `LSST_ST_HIGH_MIN + `LSST_INTEG_TAIL);
        while (got < `LSST_PIXELS) begin
            pull(rnd[3], hit, w);
            if (hit) begin
                if (got == 0) `CHK("scan_busy", 1'b1, scan_busy)
                if (got == 0) `CHK("reading", 1'b1, reading)
                if (got == 0) `CHK("integrating", 1'b0, integrating)
                `CHK("pixel", pix_word(base, got), w)
                got++;
            end
        end
        `CHK("integ_len", 20'(`LSST_ST_HIGH_MIN + `LSST_INTEG_TAIL), integ_len)
        `CHK("exposure", sat_exp(12'h080, `LSST_ST_HIGH_MIN + `LSST_INTEG_TAIL), exposure)
        `CHK("overrun", 1'b0, overrun)
        $display("test scan done");
        high_len = {11'h000, rnd[4:0]};
        k = 0;
        while (lsst_if_i.scan_start_pulse !== 1'b1 && k < 4000) begin
            pull(1'b1, hit, w);
            `CHK("extra_pixel", 1'b0, hit)
            k++;
        end
        `CHK("restart", 1'b1, lsst_if_i.scan_start_pulse)
        `CHK("reading", 1'b0, reading)
        `CHK("integrating", 1'b0, integrating)
        $display("test restart done");
        k = 0;
        while (overrun !== 1'b1 && k < 4000) begin
            pull(1'b0, hit, w);
            k++;
        end
        `CHK("overrun", 1'b1, overrun)
        `CHK("pix_valid", 1'b1, pix_valid)
        got = 0;
        base = sat_exp(12'h080, high_eff_of(high_len) + `LSST_INTEG_TAIL);
        repeat (8) begin
            pull(1'b1, hit, w);
            if (hit) begin
                `CHK("held", pix_word(base, got), w)
                got++;
            end
        end
        `CHK("held_count", `LSST_FIFO_DEPTH, got)
        `CHK("integ_len2", 20'(high_eff_of(high_len) + `LSST_INTEG_TAIL), integ_len)
        run = 1'b0;
        $display("test overrun done");
        close_out();
    end
endmodule

// ==== core/lsst_cfg.svh ====
// Timing and geometry constants for the linear sensor scan link.
// Assumes a 250 MHz system clock on both ends.
`ifndef LSST_CFG_SVH
`define LSST_CFG_SVH

// System clock period in ps and pixel clock ceiling in Hz
`define LSST_SYS_PERIOD_PS 4000
`define LSST_PIX_FMAX_HZ 10000000
// Half pixel clock in system cycles: 13 gives 250/26 = 9.6 MHz
`define LSST_PIX_HALF 13
// Scan start limits, in pixel clock periods
`define LSST_ST_CYCLE_MIN 70
`define LSST_ST_HIGH_MIN 6
`define LSST_ST_LOW_MIN 64
// Integration runs this many pixel clocks past the start pulse fall
`define LSST_INTEG_TAIL 34
// Trigger number that carries the first valid pixel
`define LSST_FIRST_TRIG 51
// Pixels per scan and the last trigger of a readout
`define LSST_PIXELS 2496
`define LSST_LAST_TRIG 2546
// Video word width and buffer depth
`define LSST_VID_W 12
`define LSST_FIFO_DEPTH 4

`endif

// ==== core/lsst_ctrl.sv ====
// Controller end: pixel clock, scan start sequencing, sample capture.
// Assumes the sensor pins arrive unsynchronised; user drains a FIFO.
`timescale 1ns/1ps
`include "lsst_cfg.svh"

// Small FIFO with valid and ready on both sides
module lsst_fifo #(
    parameter int W = 12,
    parameter int D = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic valid_r, valid_nxt;
    logic [W-1:0] head_r, head_nxt;
    logic push, pop;

    // Head word and valid flag come from flops, not from the memory mux
    assign in_ready = (cnt_r != (AW+1)'(D));
    assign out_valid = valid_r;
    assign out_data = head_r;
    assign push = in_valid & in_ready;
    assign pop = valid_r & out_ready;

    // Pointer, fill count and head update
    always_comb begin
        wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        valid_nxt = (cnt_nxt != '0);
        head_nxt = head_r;
        if (push && (wp_r == rp_nxt)) begin
            // The word written now is the only one left
            head_nxt = in_data;
        end else if (valid_nxt) begin
            head_nxt = mem[rp_nxt];
        end
    end

    // Register pointers, count and head
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            valid_r <= 1'b0;
            head_r <= '0;
        end else if (ce) begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            valid_r <= valid_nxt;
            head_r <= head_nxt;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

module lsst_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    lsst_if.ctrl_mp link,
    input wire logic run,
    input wire logic [15:0] high_len,
    output logic [`LSST_VID_W-1:0] pix_data,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic scan_busy,
    output logic overrun
);
    // Divider and sequencer
    logic [4:0] div_r, div_nxt;
    logic pclk_r, pclk_nxt;
    logic tick_fall;
    lsst_pkg::lsst_ctrl_state_t state_r, state_nxt;
    logic st_r, st_nxt;
    logic [15:0] ph_r, ph_nxt;
    logic [15:0] high_eff;
    logic busy_r, busy_nxt;
    // Capture path
    logic trig_s1_r, trig_s2_r, trig_d_r;
    lsst_pkg::lsst_video_t vid_s1_r, vid_s2_r;
    lsst_pkg::lsst_count_t tn_r, tn_nxt, sn_r, sn_nxt;
    logic push_r, push_nxt, ovr_r, ovr_nxt;
    lsst_pkg::lsst_video_t pdata_r, pdata_nxt;
    logic fifo_in_ready, fifo_empty_n;

    // Pixel clock from the system clock, under 10 MHz
    always_comb begin
        div_nxt = div_r + 5'h01;
        pclk_nxt = pclk_r;
        tick_fall = 1'b0;
        if (div_r == 5'(`LSST_PIX_HALF - 1)) begin
            div_nxt = 5'h00;
            pclk_nxt = ~pclk_r;
            tick_fall = pclk_r;
        end
    end

    // R02 high time never below minimum
    assign high_eff = (high_len < 16'(`LSST_ST_HIGH_MIN)) ? 16'(`LSST_ST_HIGH_MIN) : high_len;

    // Scan start sequencer, steps on pixel clock falls
    always_comb begin
        state_nxt = state_r;
        st_nxt = st_r;
        ph_nxt = ph_r;
        if (tick_fall) begin
            unique case (state_r)
                lsst_pkg::LSST_IDLE: begin
                    // Buffer drained before a new scan
                    if (run && !fifo_empty_n) begin
                        state_nxt = lsst_pkg::LSST_HIGH;
                        st_nxt = 1'b1;
                        ph_nxt = 16'h0001;
                    end
                end
                lsst_pkg::LSST_HIGH: begin
                    if (ph_r >= high_eff) begin
                        state_nxt = lsst_pkg::LSST_LOW;
                        st_nxt = 1'b0;
                        ph_nxt = 16'h0001;
                    end else begin
                        ph_nxt = ph_r + 16'h0001;
                    end
                end
                lsst_pkg::LSST_LOW: begin
                    // R03 low minimum; R01 follows from 6 plus 64
                    // R11 wait for every sample of this scan
                    if (ph_r >= 16'(`LSST_ST_LOW_MIN) && sn_r == 12'(`LSST_PIXELS)) begin
                        state_nxt = lsst_pkg::LSST_IDLE;
                    end else if (ph_r != 16'hffff) begin
                        ph_nxt = ph_r + 16'h0001;
                    end
                end
            endcase
        end
        busy_nxt = (state_nxt != lsst_pkg::LSST_IDLE); // Busy flag from a flop
    end

    // Register divider, sequencer and busy flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_r <= 5'h00;
            pclk_r <= 1'b0;
            state_r <= lsst_pkg::LSST_IDLE;
            st_r <= 1'b0;
            ph_r <= 16'h0000;
            busy_r <= 1'b0;
        end else if (ce) begin
            div_r <= div_nxt;
            pclk_r <= pclk_nxt;
            state_r <= state_nxt;
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Two flops on trigger and video pins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r <= 1'b0;
            vid_s1_r <= '0;
            vid_s2_r <= '0;
        end else if (ce) begin
            trig_s1_r <= link.trig;
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r;
            vid_s1_r <= link.video;
            vid_s2_r <= vid_s1_r;
        end
    end

    // Count triggers and capture the valid pixels
    always_comb begin
        tn_nxt = tn_r;
        sn_nxt = sn_r;
        push_nxt = 1'b0;
        pdata_nxt = pdata_r;
        ovr_nxt = ovr_r;
        if (tick_fall && state_r == lsst_pkg::LSST_HIGH && ph_r >= high_eff) begin
            tn_nxt = 12'h000;
            sn_nxt = 12'h000;
        end else if (trig_s2_r && !trig_d_r) begin
            // R07 sample at trigger rise
            tn_nxt = tn_r + 12'h001;
            // R06 first valid at trigger 51
            if (tn_nxt >= 12'(`LSST_FIRST_TRIG) && sn_r != 12'(`LSST_PIXELS)) begin
                sn_nxt = sn_r + 12'h001;
                push_nxt = 1'b1;
                pdata_nxt = vid_s2_r;
            end
        end
        // Sensor cannot stall: a refused word is lost and flagged
        if (push_r && !fifo_in_ready) begin
            ovr_nxt = 1'b1;
        end
    end

    // Register capture state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tn_r <= 12'h000;
            sn_r <= 12'(`LSST_PIXELS);
            push_r <= 1'b0;
            pdata_r <= '0;
            ovr_r <= 1'b0;
        end else if (ce) begin
            tn_r <= tn_nxt;
            sn_r <= sn_nxt;
            push_r <= push_nxt;
            pdata_r <= pdata_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    lsst_fifo #(
        .W(`LSST_VID_W),
        .D(`LSST_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .in_data(pdata_r),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .out_data(pix_data),
        .out_valid(fifo_empty_n),
        .out_ready(pix_ready)
    );

    assign pix_valid = fifo_empty_n;
    assign link.pix_clk = pclk_r;
    assign link.scan_start_pulse = st_r;
    assign scan_busy = busy_r;
    assign overrun = ovr_r;
endmodule

// ==== core/lsst_if.sv ====
// Pins between the linear sensor and its controller.
// Assumes both ends run on the same system clock, pins are plain wires.
`timescale 1ns/1ps

interface lsst_if;
    logic pix_clk;
    logic scan_start_pulse;
    logic trig;
    lsst_pkg::lsst_video_t video;

    modport sensor_mp (
        input pix_clk,
        input scan_start_pulse,
        output trig,
        output video
    );

    modport ctrl_mp (
        output pix_clk,
        output scan_start_pulse,
        input trig,
        input video
    );
endinterface

// ==== core/lsst_pkg.sv ====
// Types shared by both ends of the linear sensor scan link.
// Assumes lsst_cfg.svh is compiled first.
`include "lsst_cfg.svh"

package lsst_pkg;
    typedef logic [`LSST_VID_W-1:0] lsst_video_t;
    typedef logic [11:0] lsst_count_t;
    // Controller scan sequencer states
    typedef enum logic [2:0] {
        LSST_IDLE = 3'h1,
        LSST_HIGH = 3'h2,
        LSST_LOW = 3'h4
    } lsst_ctrl_state_t;
endpackage

// ==== core/lsst_sensor.sv ====
// Sensor end: integration and serial pixel readout timing.
// Assumes pixel clock and scan start arrive as unsynchronised pins.
// The start pulse timing is the controller's duty; it is not checked here.
`timescale 1ns/1ps
`include "lsst_cfg.svh"

// Summary of operation
// R01: Start pulse rising edges at least 70 clocks apart
// R02: Start pulse high at least 6 clocks
// R03: Start pulse low at least 64 clocks
// R04: Integration equals high time plus 34 clocks
// R05: Shifting begins first clock after start falls
// R06: First valid pixel at trigger number 51
// R07: One trigger per pixel, sample at rise
// R08: One pixel per clock, 10 MHz maximum
// R09: All pixels integrate during one interval
// R10: Each scan delivers 2496 pixels
// R11: No new scan before all samples taken
module lsst_sensor (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    lsst_if.sensor_mp link,
    input wire logic [`LSST_VID_W-1:0] light_level,
    output logic integrating,
    output logic reading,
    output logic [19:0] integ_len,
    output logic [`LSST_VID_W-1:0] exposure
);
    // Pin synchronisers
    logic pclk_s1_r;
    logic pclk_s2_r;
    logic pclk_d_r;
    logic st_s1_r;
    logic st_s2_r;

    // Integration window state
    logic st_prev_r;
    logic st_prev_nxt;
    logic integ_r;
    logic integ_nxt;
    logic [5:0] tail_r;
    logic [5:0] tail_nxt;
    logic [19:0] len_r;
    logic [19:0] len_nxt;
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic [`LSST_VID_W-1:0] exp_r;
    logic [`LSST_VID_W-1:0] exp_nxt;

    // Readout state
    logic read_r;
    logic read_nxt;
    lsst_pkg::lsst_count_t tcnt_r;
    lsst_pkg::lsst_count_t tcnt_nxt;
    logic trig_r;
    logic trig_nxt;
    lsst_pkg::lsst_video_t video_r;
    lsst_pkg::lsst_video_t video_nxt;

    // Decodes
    logic pix_rise;
    logic pix_fall;
    logic tail_last;
    lsst_pkg::lsst_count_t next_trig;
    lsst_pkg::lsst_count_t pix_idx;
    logic [31:0] acc_sum;

    // Two flops on each incoming pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pclk_s1_r <= 1'b0;
            pclk_s2_r <= 1'b0;
            pclk_d_r <= 1'b0;
            st_s1_r <= 1'b0;
            st_s2_r <= 1'b0;
        end else if (ce) begin
            pclk_s1_r <= link.pix_clk;
            pclk_s2_r <= pclk_s1_r;
            pclk_d_r <= pclk_s2_r;
            st_s1_r <= link.scan_start_pulse;
            st_s2_r <= st_s1_r;
        end
    end

    // R08 one pixel per clock
    assign pix_rise = pclk_s2_r & ~pclk_d_r;
    assign pix_fall = ~pclk_s2_r & pclk_d_r;

    // Next trigger number, running sum, last tail clock
    assign next_trig = tcnt_r + 12'h001;
    assign acc_sum = acc_r + {20'h00000, light_level};
    assign tail_last = (tail_r == 6'(`LSST_INTEG_TAIL - 1));

    // Pixel index for the trigger about to be raised
    always_comb begin
        pix_idx = 12'h000;
        if (next_trig >= 12'(`LSST_FIRST_TRIG)) begin
            pix_idx = next_trig - 12'(`LSST_FIRST_TRIG);
        end
    end

    // Integration: one shared window for every pixel
    always_comb begin
        st_prev_nxt = st_prev_r;
        integ_nxt = integ_r;
        tail_nxt = tail_r;
        len_nxt = len_r;
        acc_nxt = acc_r;
        exp_nxt = exp_r;
        if (pix_rise) begin
            st_prev_nxt = st_s2_r;
            if (st_s2_r && !st_prev_r) begin
                // R09 common window opens
                integ_nxt = 1'b1;
                tail_nxt = 6'h00;
                len_nxt = 20'h00001;
                acc_nxt = {20'h00000, light_level};
            end else if (integ_r) begin
                len_nxt = len_r + 20'h00001;
                acc_nxt = acc_sum;
                if (!st_s2_r) begin
                    // R04 high time plus tail
                    tail_nxt = tail_r + 6'h01;
                    if (tail_last) begin
                        // Last tail clock still counts; close and saturate
                        integ_nxt = 1'b0;
                        exp_nxt = (acc_sum[31:`LSST_VID_W] != '0) ? '1 : acc_sum[`LSST_VID_W-1:0];
                    end
                end
            end
        end
    end

    // Register integration state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_prev_r <= 1'b0;
            integ_r <= 1'b0;
            tail_r <= 6'h00;
            len_r <= 20'h00000;
            acc_r <= 32'h00000000;
            exp_r <= '0;
        end else if (ce) begin
            st_prev_r <= st_prev_nxt;
            integ_r <= integ_nxt;
            tail_r <= tail_nxt;
            len_r <= len_nxt;
            acc_r <= acc_nxt;
            exp_r <= exp_nxt;
        end
    end

    // Readout: triggers and video words
    always_comb begin
        read_nxt = read_r;
        tcnt_nxt = tcnt_r;
        trig_nxt = trig_r;
        video_nxt = video_r;
        if (pix_rise) begin
            if (!st_s2_r && st_prev_r) begin
                // R05 shift starts on first clock after fall
                read_nxt = 1'b1;
                tcnt_nxt = 12'h001;
                trig_nxt = 1'b1;
            end else if (read_r) begin
                if (tcnt_r == 12'(`LSST_LAST_TRIG)) begin
                    // R10 readout ends after the last pixel
                    read_nxt = 1'b0;
                end else begin
                    // R07 one trigger per pixel
                    tcnt_nxt = next_trig;
                    trig_nxt = 1'b1;
                end
            end
        end else if (pix_fall) begin
            trig_nxt = 1'b0;
            // R06 video settles before the trigger rises
            if (next_trig >= 12'(`LSST_FIRST_TRIG) && next_trig <= 12'(`LSST_LAST_TRIG)) begin
                video_nxt = exp_r ^ pix_idx;
            end else begin
                video_nxt = '0;
            end
        end
    end

    // Register readout state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            read_r <= 1'b0;
            tcnt_r <= 12'h000;
            trig_r <= 1'b0;
            video_r <= '0;
        end else if (ce) begin
            read_r <= read_nxt;
            tcnt_r <= tcnt_nxt;
            trig_r <= trig_nxt;
            video_r <= video_nxt;
        end
    end

    // Link pins straight from flops
    assign link.trig = trig_r;
    assign link.video = video_r;

    // User status straight from flops
    assign integrating = integ_r;
    assign reading = read_r;
    assign integ_len = len_r;
    assign exposure = exp_r;
endmodule
